/* File: design/gst_params.svh */
// gated sixteen bit timer: offsets, field positions, reset values and counts
// assumes inclusion by bare name from the timer design file
`ifndef GST_PARAMS_SVH
`define GST_PARAMS_SVH
// byte offsets of the register words
`define GST_OFS_CTRL  5'h00
`define GST_OFS_GCTRL 5'h04
`define GST_OFS_GSEL  5'h08
`define GST_OFS_CNTL  5'h0C
`define GST_OFS_CNTH  5'h10
`define GST_OFS_FLAGS 5'h14
`define GST_OFS_IEN   5'h18
`define GST_OFS_CSRC  5'h1C
// gate control fields
`define GST_B_GME 7
`define GST_B_POL 6
`define GST_B_TGL 5
`define GST_B_SPM 4
`define GST_B_ARM 3
`define GST_B_LVL 2
// flag and enable fields
`define GST_B_ROLL 0
`define GST_B_GEV  1
// reset values and counts
`define GST_RST_CTRL  5'h00
`define GST_RST_GSEL  5'h00
`define GST_CNT_MAX   16'hFFFF
`define GST_CNT_ZERO  16'h0000
`define GST_INSTR_PH  2'h3
`define GST_BYTE_W    8
`endif

/* File: design/gst_pkg.sv */
// gated sixteen bit timer: shared types
// assumes gst_params.svh is on the include path
package gst_pkg;
  // timer control fields in register order
  typedef struct packed {
    logic [1:0] prescale_select;
    logic       sync_bypass;
    logic       wide_access_enable;
    logic       timer_on;
  } gst_ctrl_s;

  // avalon request carrier
  typedef struct packed {
    logic [4:0]  address;
    logic        read;
    logic        write;
    logic [31:0] writedata;
  } gst_av_req_s;

  // single-pulse acquisition states
  typedef enum logic [1:0] {
    GST_SP_IDLE,
    GST_SP_ARMED,
    GST_SP_RUN
  } gst_sp_e;
endpackage : gst_pkg

/* File: design/gst_timer.sv */
// gated sixteen bit timer with gate logic and avalon-mm register slave
// assumes one clock, capture/compare units on the same clock, async gate pins
// Functional notes
// RULE1: five-bit gate source select, then polarity
// RULE2: toggle flop flips on each gate rising edge
// RULE3: toggle flop held zero while toggle disabled
// RULE4: armed single pulse starts on next edge
// RULE5: trailing edge clears armed; later events ignored
// RULE6: clearing single-pulse enable clears armed bit
// RULE7: toggle plus single pulse counts one period
// RULE8: gate level readable, independent of gate enable
// RULE9: gate level falling edge sets gate flag
// RULE10: gate flag works with gate mode off
// RULE11: count wraps FFFF to zero, sets rollover
// RULE12: rollover irq needs on, enable, global enable
// RULE13: sleep counting only in asynchronous counter mode
// RULE14: capture event copies count to capture register
// RULE15: compare match when value equals count
// RULE16: special trigger zeroes count, no rollover flag
// RULE17: count write wins over special trigger
// RULE18: software should use synchronised mode for triggers
// RULE19: module disable holds timer in reset
// RULE20: prescale codes divide by one, two, four, eight
// RULE21: sync bit resynchronises external clock only
// RULE22: wide access bit gives 16-bit count access
// RULE23: gated mode counts only while gate active
// RULE24: only low byte writes clear prescaler
// RULE25: gate path order ends in one enable
// RULE26: timer on bit starts and holds counting
`include "gst_params.svh"
module gst_timer (
  // clock and reset
  input  wire logic                sys_clk,
  input  wire logic                sys_rst,
  input  wire logic                module_disable,
  // register bus
  input  wire gst_pkg::gst_av_req_s av_req,
  output logic [31:0]              av_readdata,
  output logic                     av_waitrequest,
  // asynchronous sources
  input  wire logic [31:0]         gate_sources,
  input  wire logic                ext_clk_in,
  // core status and requests
  input  wire logic                sleep_mode,
  input  wire logic                global_irq_enable,
  output logic                     rollover_irq,
  output logic                     gate_irq,
  output logic                     wake_req,
  // capture/compare units
  input  wire logic                capture_event,
  input  wire logic                compare_enable,
  input  wire logic [15:0]         compare_value,
  input  wire logic                special_trigger,
  output logic [15:0]              count_pair,
  output logic [15:0]              capture_compare_value,
  output logic                     compare_match
);
  logic                rst;
  logic                ack_ff;
  logic                req;
  logic                wr_go;
  logic                rd_cap;
  logic [7:0]          wd;
  gst_pkg::gst_ctrl_s  ctrl_ff;
  logic                gme_ff;
  logic                pol_ff;
  logic                tgl_en_ff;
  logic                spm_ff;
  logic [4:0]          gsel_ff;
  logic                clk_ext_ff;
  logic [1:0]          ien_ff;
  logic [31:0]         gs_meta_ff;
  logic [31:0]         gs_sync_ff;
  logic                ext_meta_ff;
  logic                ext_sync_ff;
  logic                ext_res_ff;
  logic                ext_prev_ff;
  logic                ext_sig;
  logic [1:0]          div_ff;
  logic                src_tick;
  logic                async_mode;
  logic [2:0]          presc_ff;
  logic [2:0]          pmask;
  logic                presc_tick;
  logic                gsel_sig;
  logic                gpol;
  logic                gpol_prev_ff;
  logic                tog_ff;
  logic                gt;
  logic                gt_prev_ff;
  logic                gt_rise;
  logic                gt_fall;
  gst_pkg::gst_sp_e    sp_ff;
  logic                gate_level;
  logic                glvl_prev_ff;
  logic                roll_flag_ff;
  logic                gev_flag_ff;
  logic [15:0]         cnt_ff;
  logic [7:0]          hbuf_ff;
  logic                wr_lo;
  logic                wr_hi;
  logic                cnt_wr;
  logic                inc;
  logic                wrap;
  logic [31:0]         rd_mux;
  logic [31:0]         rdata_ff;
  logic [15:0]         cap_ff;
  logic                cmp_ff;

  // true when the bus address of this cycle matches the given offset
  function automatic logic hit(input logic [4:0] a, input logic [4:0] ofs);
    hit = (a == ofs);
  endfunction : hit

  // module disable acts as a reset of every flop
  assign rst = sys_rst | module_disable;  // see RULE19

  // bus handshake: one wait state per access
  assign req            = av_req.read | av_req.write;
  assign av_waitrequest = req & ~ack_ff;
  assign wr_go          = av_req.write & ack_ff;
  assign rd_cap         = av_req.read & ~ack_ff;
  assign wd             = av_req.writedata[7:0];
  assign wr_lo          = wr_go & hit(av_req.address, `GST_OFS_CNTL);
  assign wr_hi          = wr_go & hit(av_req.address, `GST_OFS_CNTH) & ~ctrl_ff.wide_access_enable;
  assign cnt_wr         = wr_lo | wr_hi;

  // handshake phase flop
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      ack_ff <= 1'b0;
    else
      ack_ff <= req & ~ack_ff;
  end

  // software-written control registers
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      ctrl_ff    <= `GST_RST_CTRL;
      gme_ff     <= 1'b0;
      pol_ff     <= 1'b0;
      tgl_en_ff  <= 1'b0;
      spm_ff     <= 1'b0;
      gsel_ff    <= `GST_RST_GSEL;
      clk_ext_ff <= 1'b0;
      ien_ff     <= 2'h0;
    end
    else if (wr_go)
    begin
      case (av_req.address)
        `GST_OFS_CTRL:
        begin
          ctrl_ff.prescale_select    <= av_req.writedata[5:4];
          ctrl_ff.sync_bypass        <= av_req.writedata[2];
          ctrl_ff.wide_access_enable <= av_req.writedata[1];
          ctrl_ff.timer_on           <= av_req.writedata[0];
        end
        `GST_OFS_GCTRL:
        begin
          gme_ff    <= av_req.writedata[`GST_B_GME];
          pol_ff    <= av_req.writedata[`GST_B_POL];
          tgl_en_ff <= av_req.writedata[`GST_B_TGL];
          spm_ff    <= av_req.writedata[`GST_B_SPM];
        end
        `GST_OFS_GSEL: gsel_ff    <= av_req.writedata[4:0];
        `GST_OFS_IEN:  ien_ff     <= av_req.writedata[1:0];
        `GST_OFS_CSRC: clk_ext_ff <= av_req.writedata[0];
        default:       ;
      endcase
    end
  end

  // two-flop synchronisers for gate sources and external clock
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      gs_meta_ff  <= 32'h0000_0000;
      gs_sync_ff  <= 32'h0000_0000;
      ext_meta_ff <= 1'b0;
      ext_sync_ff <= 1'b0;
      ext_res_ff  <= 1'b0;
      ext_prev_ff <= 1'b0;
    end
    else
    begin
      gs_meta_ff  <= gate_sources;
      gs_sync_ff  <= gs_meta_ff;
      ext_meta_ff <= ext_clk_in;
      ext_sync_ff <= ext_meta_ff;
      ext_res_ff  <= ext_sync_ff;
      ext_prev_ff <= ext_sig;
    end
  end

  // clock source: instruction-rate tick or external rising edge
  assign ext_sig    = ctrl_ff.sync_bypass ? ext_sync_ff : ext_res_ff;  // see RULE21
  assign src_tick   = clk_ext_ff ? (ext_sig & ~ext_prev_ff) : (div_ff == `GST_INSTR_PH);
  assign async_mode = clk_ext_ff & ctrl_ff.sync_bypass;

  // divide-by-four instruction phase counter
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      div_ff <= 2'h0;
    else
      div_ff <= div_ff + 2'h1;
  end

  // prescale mask: codes 0..3 give divide by 1, 2, 4, 8
  always_comb
  begin
    case (ctrl_ff.prescale_select)  // see RULE20
      2'h0:    pmask = 3'h0;
      2'h1:    pmask = 3'h1;
      2'h2:    pmask = 3'h3;
      default: pmask = 3'h7;
    endcase
  end
  assign presc_tick = src_tick & (presc_ff == pmask);

  // prescale counter, cleared by low byte writes only
  always_ff @(posedge sys_clk)
  begin
    if (rst || wr_lo)  // see RULE24
      presc_ff <= 3'h0;
    else if (src_tick && ctrl_ff.timer_on)
      presc_ff <= presc_tick ? 3'h0 : presc_ff + 3'h1;
  end

  // gate path: select, polarity, toggle, single pulse
  assign gsel_sig   = gs_sync_ff[gsel_ff];            // see RULE1
  assign gpol       = pol_ff ? gsel_sig : ~gsel_sig;  // see RULE1
  assign gt         = tgl_en_ff ? tog_ff : gpol;      // see RULE25
  assign gt_rise    = gt & ~gt_prev_ff;
  assign gt_fall    = ~gt & gt_prev_ff;
  assign gate_level = spm_ff ? ((sp_ff == gst_pkg::GST_SP_RUN) & gt) : gt;  // see RULE7

  // edge history of the gate stages
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      gpol_prev_ff <= 1'b0;
      gt_prev_ff   <= 1'b0;
      glvl_prev_ff <= 1'b0;
    end
    else
    begin
      gpol_prev_ff <= gpol;
      gt_prev_ff   <= gt;
      glvl_prev_ff <= gate_level;
    end
  end

  // toggle flop
  always_ff @(posedge sys_clk)
  begin
    if (rst || !tgl_en_ff)  // see RULE3
      tog_ff <= 1'b0;
    else if (gpol && !gpol_prev_ff)
      tog_ff <= ~tog_ff;  // see RULE2
  end

  // single-pulse acquisition sequencer
  always_ff @(posedge sys_clk)
  begin
    if (rst || !spm_ff)  // see RULE6
      sp_ff <= gst_pkg::GST_SP_IDLE;
    else
    begin
      case (sp_ff)
        gst_pkg::GST_SP_IDLE:
          if (wr_go && hit(av_req.address, `GST_OFS_GCTRL) && av_req.writedata[`GST_B_ARM])
            sp_ff <= gst_pkg::GST_SP_ARMED;  // see RULE4
        gst_pkg::GST_SP_ARMED:
          if (gt_rise)
            sp_ff <= gst_pkg::GST_SP_RUN;  // see RULE4
        gst_pkg::GST_SP_RUN:
          if (gt_fall)
            sp_ff <= gst_pkg::GST_SP_IDLE;  // see RULE5
        default:
          sp_ff <= gst_pkg::GST_SP_IDLE;
      endcase
    end
  end

  // count enable: on, gate, prescaled tick, sleep qualification
  assign inc  = ctrl_ff.timer_on & (~gme_ff | gate_level) & presc_tick  // see RULE26 and RULE23
              & (~sleep_mode | async_mode);                               // see RULE13
  assign wrap = inc & ~cnt_wr & ~special_trigger & (cnt_ff == `GST_CNT_MAX);

  // count register: write, then trigger, then increment
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      cnt_ff <= `GST_CNT_ZERO;
    else if (wr_lo)  // see RULE17
      cnt_ff <= ctrl_ff.wide_access_enable ? {hbuf_ff, wd} : {cnt_ff[15:8], wd};  // see RULE22
    else if (wr_hi)
      cnt_ff <= {wd, cnt_ff[7:0]};
    else if (special_trigger)
      cnt_ff <= `GST_CNT_ZERO;  // see RULE16
    else if (inc)
      cnt_ff <= cnt_ff + 16'h0001;  // see RULE11
  end

  // high byte buffer for wide access
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      hbuf_ff <= 8'h00;
    else if (ctrl_ff.wide_access_enable && rd_cap && hit(av_req.address, `GST_OFS_CNTL))
      hbuf_ff <= cnt_ff[15:8];  // see RULE22
    else if (ctrl_ff.wide_access_enable && wr_go && hit(av_req.address, `GST_OFS_CNTH))
      hbuf_ff <= wd;
  end

  // sticky flags, write one to clear, set wins
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      roll_flag_ff <= 1'b0;
      gev_flag_ff  <= 1'b0;
    end
    else
    begin
      roll_flag_ff <= wrap | (roll_flag_ff & ~(wr_go & hit(av_req.address, `GST_OFS_FLAGS)
                    & av_req.writedata[`GST_B_ROLL]));  // see RULE11
      gev_flag_ff  <= (glvl_prev_ff & ~gate_level)      // see RULE9 and RULE10
                    | (gev_flag_ff & ~(wr_go & hit(av_req.address, `GST_OFS_FLAGS)
                    & av_req.writedata[`GST_B_GEV]));
    end
  end

  // interrupt and wake requests
  assign rollover_irq = roll_flag_ff & ien_ff[`GST_B_ROLL] & ctrl_ff.timer_on & global_irq_enable;  // see RULE12
  assign gate_irq     = gev_flag_ff & ien_ff[`GST_B_GEV];  // see RULE9
  assign wake_req     = sleep_mode & roll_flag_ff & ien_ff[`GST_B_ROLL] & ctrl_ff.timer_on;  // see RULE13

  // read data selection
  always_comb
  begin
    rd_mux = 32'h0000_0000;
    case (av_req.address)
      `GST_OFS_CTRL:  rd_mux[5:0] = {ctrl_ff.prescale_select, 1'b0, ctrl_ff.sync_bypass,
                                     ctrl_ff.wide_access_enable, ctrl_ff.timer_on};
      `GST_OFS_GCTRL: rd_mux[7:2] = {gme_ff, pol_ff, tgl_en_ff, spm_ff,
                                     sp_ff != gst_pkg::GST_SP_IDLE, gate_level};  // see RULE8
      `GST_OFS_GSEL:  rd_mux[4:0] = gsel_ff;
      `GST_OFS_CNTL:  rd_mux[7:0] = cnt_ff[7:0];
      `GST_OFS_CNTH:  rd_mux[7:0] = ctrl_ff.wide_access_enable ? hbuf_ff : cnt_ff[15:8];
      `GST_OFS_FLAGS: rd_mux[1:0] = {gev_flag_ff, roll_flag_ff};
      `GST_OFS_IEN:   rd_mux[1:0] = ien_ff;
      `GST_OFS_CSRC:  rd_mux[0]   = clk_ext_ff;
      default:        rd_mux      = 32'h0000_0000;
    endcase
  end

  // read data register, loaded in the wait cycle
  always_ff @(posedge sys_clk)
  begin
    if (rst)
      rdata_ff <= 32'h0000_0000;
    else if (rd_cap)
      rdata_ff <= rd_mux;
  end
  assign av_readdata = rdata_ff;

  // capture and compare for the capture/compare units
  always_ff @(posedge sys_clk)
  begin
    if (rst)
    begin
      cap_ff <= `GST_CNT_ZERO;
      cmp_ff <= 1'b0;
    end
    else
    begin
      if (capture_event)
        cap_ff <= cnt_ff;  // see RULE14
      cmp_ff <= compare_enable & (compare_value == cnt_ff);  // see RULE15
    end
  end
  assign count_pair            = cnt_ff;
  assign capture_compare_value = cap_ff;
  assign compare_match         = cmp_ff;

  // checks on the timer behaviour
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  AST_TOGGLE_HELD: assert property (!tgl_en_ff |=> !tog_ff)  // see RULE3
    else $error("toggle flop not held clear");
  AST_WRAP: assert property (wrap |=> (cnt_ff == `GST_CNT_ZERO) && roll_flag_ff)  // see RULE11
    else $error("wrap did not zero count and set flag");
  AST_TRIGGER: assert property ((special_trigger && !cnt_wr) |=> (cnt_ff == `GST_CNT_ZERO)
    && !$rose(roll_flag_ff))  // see RULE16
    else $error("special trigger misbehaved");
  AST_WRITE_WINS: assert property ((wr_lo && special_trigger) |=> cnt_ff[7:0] == $past(wd))  // see RULE17
    else $error("trigger beat a count write");
  AST_SPM_CLEAR: assert property (!spm_ff |=> sp_ff == gst_pkg::GST_SP_IDLE)  // see RULE6
    else $error("armed bit survived single pulse disable");
  AST_PULSE_END: assert property ((sp_ff == gst_pkg::GST_SP_RUN && gt_fall && spm_ff)
    |=> sp_ff == gst_pkg::GST_SP_IDLE ##1 !gate_level)  // see RULE5
    else $error("trailing edge did not end pulse");
  AST_GATE_FLAG: assert property ((glvl_prev_ff && !gate_level) |=> gev_flag_ff)  // see RULE9
    else $error("gate event flag not set");
  AST_OFF_HOLD: assert property ((!ctrl_ff.timer_on && !cnt_wr && !special_trigger) |=> $stable(cnt_ff))  // see RULE26
    else $error("count moved while off");
  AST_GATE_HOLD: assert property ((gme_ff && !gate_level && !cnt_wr && !special_trigger)
    |=> $stable(cnt_ff))  // see RULE23
    else $error("count moved with gate inactive");
  AST_CAPTURE: assert property (capture_event |=> capture_compare_value == $past(cnt_ff))  // see RULE14
    else $error("capture value wrong");
endmodule : gst_timer

/* File: verification/gst_ccp_model.sv */
// capture/compare unit model: compare period and special event trigger
// assumes the timer runs from the synchronised system clock tick
module gst_ccp_model (
  // clock and reset
  input  wire logic        sys_clk,
  input  wire logic        sys_rst,
  // bench control
  input  wire logic        use_trig,
  input  wire logic [15:0] period,
  // timer side
  input  wire logic        compare_match,
  output logic             compare_enable,
  output logic [15:0]      compare_value,
  output logic             special_trigger
);
  timeunit 1ns;
  timeprecision 1ns;

  // compare value acts as the counting period
  assign compare_enable = use_trig;
  assign compare_value  = period;

  // trigger only while the bench keeps the timer on the synchronised tick
  always_ff @(posedge sys_clk)
  begin
    special_trigger <= !sys_rst && use_trig && compare_match;
  end
endmodule : gst_ccp_model

/* File: verification/gated_sixteen_bit_timer_tb.sv */
// self-checking bench of the gated sixteen bit timer
// assumes gst_pkg compiled first and gst_params.svh on the include path
module gated_sixteen_bit_timer_tb;
  timeunit 1ns;
  timeprecision 1ns;
  logic                sys_clk, sys_rst, module_disable, sleep_mode, gie, ext_clk;
  logic                capture_event, use_trig, av_waitrequest, rollover_irq;
  logic                gate_irq, wake_req, compare_enable, special_trigger, compare_match;
  gst_pkg::gst_av_req_s av_req;
  logic [31:0]         av_readdata, gate_sources, rd;
  logic [15:0]         compare_value, count_pair, capture_compare_value, period, c0, mx;
  int                  err_total, compares, p;

  gst_timer i_dut (.sys_clk(sys_clk), .sys_rst(sys_rst), .module_disable(module_disable),
    .av_req(av_req), .av_readdata(av_readdata), .av_waitrequest(av_waitrequest),
    .gate_sources(gate_sources), .ext_clk_in(ext_clk), .sleep_mode(sleep_mode),
    .global_irq_enable(gie), .rollover_irq(rollover_irq), .gate_irq(gate_irq),
    .wake_req(wake_req), .capture_event(capture_event), .compare_enable(compare_enable),
    .compare_value(compare_value), .special_trigger(special_trigger), .count_pair(count_pair),
    .capture_compare_value(capture_compare_value), .compare_match(compare_match));

  gst_ccp_model i_ccp (.sys_clk(sys_clk), .sys_rst(sys_rst), .use_trig(use_trig),
    .period(period), .compare_match(compare_match), .compare_enable(compare_enable),
    .compare_value(compare_value), .special_trigger(special_trigger));

  // 25 MHz clock
  initial
  begin
    sys_clk = 1'b0;
    forever #20 sys_clk = ~sys_clk;
  end

  // print counts and verdict, then stop
  task give_verdict;
    $display("counts: %0d compares, %0d mismatches", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : give_verdict

  // compare seen against expected
  task chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp)
    begin
      err_total++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask : chk

  // wait n clock edges
  task tk(input int n);
    repeat (n) @(posedge sys_clk);
  endtask : tk

  // one avalon access, held until waitrequest is sampled low
  task bus(input logic [4:0] a, input logic w, input logic [31:0] d);
    int n;
    @(posedge sys_clk);
    av_req <= '{address: a, read: !w, write: w, writedata: d};
    for (n = 0; n < 16; n++)
    begin
      @(posedge sys_clk);
      if (av_waitrequest === 1'b0) break;
    end
    if (n == 16)
    begin
      err_total++;
      give_verdict();
    end
    rd = av_readdata;
    av_req <= '0;
    @(posedge sys_clk);  // let the completed access settle before callers look
  endtask : bus

  task wr(input logic [4:0] a, input logic [31:0] d);
    bus(a, 1'b1, d);
  endtask : wr

  task rdv(input logic [4:0] a);
    bus(a, 1'b0, 32'h0);
  endtask : rdv

  // one gate pulse on source five, high then low for n cycles each
  task pulse(input int n);
    gate_sources[5] <= 1'b1;
    tk(n);
    gate_sources[5] <= 1'b0;
    tk(n);
  endtask : pulse

  // stop, clear the count and the prescaler
  task clr;
    wr(5'h00, 32'h0);
    wr(5'h10, 32'h0);
    wr(5'h0C, 32'h0);
  endtask : clr

  // reset values, wrap, rollover flag and interrupt gating
  task t_roll;
    rdv(5'h00); chk(rd, 32'h0);
    rdv(5'h14); chk(rd, 32'h0);
    wr(5'h10, 32'hFF); wr(5'h0C, 32'hFF); wr(5'h18, 32'h1);
    gie <= 1'b1;
    wr(5'h00, 32'h1);
    for (p = 0; p < 40 && rd[0] !== 1'b1; p++) rdv(5'h14);
    chk(rd[0], 1'b1);
    chk(count_pair < 16'h0010, 1'b1);
    chk(rollover_irq, 1'b1);
    gie <= 1'b0;
    tk(1);
    chk(rollover_irq, 1'b0);
    gie <= 1'b1;
    wr(5'h00, 32'h0);
    chk(rollover_irq, 1'b0);
    wr(5'h14, 32'h1); rdv(5'h14);
    chk(rd[0], 1'b0);
    $display("done: rollover");
  endtask : t_roll

  // every prescale code over a fixed window, then hold when off
  task t_pre;
    for (p = 0; p < 4; p++)
    begin
      clr();
      wr(5'h00, (p << 4) | 1);
      tk(256);
      c0 = count_pair;
      chk(c0 + 2 >= (64 >> p) && c0 <= (64 >> p) + 1, 1'b1);
    end
    wr(5'h00, 32'h0);
    c0 = count_pair;
    tk(20);
    chk(count_pair, c0);
    $display("done: prescale");
  endtask : t_pre

  // gated counting, polarity, selection, level and gate event flag
  task t_gate;
    wr(5'h08, 32'h5); wr(5'h04, 32'hC0); wr(5'h00, 32'h1);
    c0 = count_pair; tk(40);
    chk(count_pair, c0);
    gate_sources[5] <= 1'b1; tk(4);
    rdv(5'h04); chk(rd[2], 1'b1);
    c0 = count_pair; tk(40);
    chk(count_pair > c0, 1'b1);
    wr(5'h18, 32'h2);
    gate_sources[5] <= 1'b0; tk(6);
    rdv(5'h14); chk(rd[1], 1'b1);
    chk(gate_irq, 1'b1);
    wr(5'h14, 32'h2); wr(5'h04, 32'h40);
    gate_sources[5] <= 1'b1; tk(6);
    rdv(5'h04); chk(rd[2], 1'b1);
    gate_sources[5] <= 1'b0; tk(6);
    rdv(5'h14); chk(rd[1], 1'b1);
    wr(5'h14, 32'h2);
    gate_sources[6] <= 1'b1; tk(6);
    rdv(5'h04); chk(rd[2], 1'b0);
    gate_sources[6] <= 1'b0;
    wr(5'h04, 32'h80);
    c0 = count_pair; tk(40);
    chk(count_pair > c0, 1'b1);
    $display("done: gate");
  endtask : t_gate

  // toggle mode, forced clear, single pulse and both together
  task t_mode;
    wr(5'h04, 32'hE0);
    pulse(40);
    wr(5'h04, 32'hC0);
    c0 = count_pair; tk(20);
    chk(count_pair, c0);
    wr(5'h04, 32'hE0);
    c0 = count_pair; pulse(40);
    chk(count_pair - c0 >= 18 && count_pair - c0 <= 21, 1'b1);
    gate_sources[5] <= 1'b1; tk(4);
    c0 = count_pair; tk(36);
    gate_sources[5] <= 1'b0; tk(40);
    chk(count_pair, c0);
    wr(5'h04, 32'hD0); wr(5'h04, 32'hD8);
    rdv(5'h04); chk(rd[3], 1'b1);
    c0 = count_pair; tk(40);
    chk(count_pair, c0);
    pulse(40);
    chk(count_pair - c0 >= 8 && count_pair - c0 <= 11, 1'b1);
    rdv(5'h04); chk(rd[3], 1'b0);
    c0 = count_pair; pulse(40);
    chk(count_pair, c0);
    wr(5'h04, 32'hD8); wr(5'h04, 32'hC8);
    rdv(5'h04); chk(rd[3], 1'b0);
    wr(5'h04, 32'hF0); wr(5'h04, 32'hF8);
    c0 = count_pair;
    pulse(40); pulse(40); pulse(40);
    chk(count_pair - c0 >= 18 && count_pair - c0 <= 21, 1'b1);
    $display("done: gate modes");
  endtask : t_mode

  // compare match and special trigger set the period without rollover
  task t_trig;
    clr();
    wr(5'h04, 32'h0); wr(5'h14, 32'h3);
    period <= 16'h0014;
    use_trig <= 1'b1;
    wr(5'h00, 32'h1);
    mx = 16'h0;
    for (p = 0; p < 400; p++)
    begin
      tk(1);
      if (count_pair > mx) mx = count_pair;
    end
    chk(mx >= 16'h0014 && mx <= 16'h0015, 1'b1);
    rdv(5'h14); chk(rd[0], 1'b0);
    clr();
    period <= 16'h0000;
    tk(4);
    wr(5'h0C, 32'h5A);
    chk(count_pair, 16'h005A);
    use_trig <= 1'b0;
    $display("done: special trigger");
  endtask : t_trig

  // wide access, capture, sleep and module disable
  task t_misc;
    wr(5'h00, 32'h2);
    c0 = count_pair;
    wr(5'h10, 32'h12);
    chk(count_pair, c0);
    wr(5'h0C, 32'h34);
    chk(count_pair, 16'h1234);
    capture_event <= 1'b1; tk(1);
    capture_event <= 1'b0; tk(1);
    chk(capture_compare_value, 16'h1234);
    rdv(5'h0C); chk(rd[7:0], 8'h34);
    rdv(5'h10); chk(rd[7:0], 8'h12);
    sleep_mode <= 1'b1;
    wr(5'h00, 32'h1);
    tk(40);
    chk(count_pair, 16'h1234);
    chk(wake_req, 1'b0);
    wr(5'h1C, 32'h1); wr(5'h18, 32'h1); wr(5'h10, 32'hFF); wr(5'h0C, 32'hFF);
    wr(5'h00, 32'h5);
    repeat (2)
    begin
      ext_clk <= 1'b1; tk(4);
      ext_clk <= 1'b0; tk(4);
    end
    chk(count_pair, 16'h0001);
    chk(wake_req, 1'b1);
    sleep_mode <= 1'b0;
    module_disable <= 1'b1; tk(3);
    chk(count_pair, 16'h0);
    module_disable <= 1'b0;
    rdv(5'h00); chk(rd, 32'h0);
    $display("done: access and disable");
  endtask : t_misc

  // main sequence
  initial
  begin
    sys_rst = 1'b1; module_disable = 1'b0; sleep_mode = 1'b0; gie = 1'b0;
    capture_event = 1'b0; use_trig = 1'b0; period = 16'h0; gate_sources = 32'h0;
    av_req = '0; rd = 32'h0; err_total = 0; compares = 0; ext_clk = 1'b0;
    tk(3);
    sys_rst <= 1'b0;
    t_roll(); t_pre(); t_gate(); t_mode(); t_trig(); t_misc();
    give_verdict();
  end
endmodule : gated_sixteen_bit_timer_tb
